// file: core/rxmb_top.sv
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - buffer delivers data, reception info, slot status
// - config region: software only, device untouched
// - message region: software only on data/status
// - reception region: device write only
// - search region: device reads search fields only
// - triggers and irq enable always writable
// - device updates state bits at any time
// - irq flag shared, device set wins
// - idle reads enabled 1 locked 0, searched
// - disabled states give config access, unsearched
// - locked states read 1/1, message access
// - subscribed: no access by either party
// - receiving: data goes to shadow buffer
// - status update writes status via reception region
// - only enabled and locked bits visible
// - enable trigger toggles; disable sometimes ignored
// - lock trigger toggles; lock refused while receiving
// - search, slot start, segment start advance state
// - device transition applied before software one
module rxmb_top
    import rxmb_pkg::*;
(
    // clock and reset
    input  wire logic            clk,
    input  wire logic            srst,
    // apb slave
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [7:0]      paddr,
    input  wire logic [31:0]     pwdata,
    output logic [31:0]          prdata,
    output logic                 pready,
    output logic                 pslverr,
    // protocol engine
    input  wire rxmb_events_type ev,
    input  wire rxmb_update_type upd,
    input  wire logic            shadow_valid,
    input  wire logic [31:0]     shadow_data,
    // buffer view for the search logic
    output logic                 search_included,
    output logic [31:0]          search_cfg,
    output logic                 shadow_select,
    output logic                 lock_error_flag
);
    rxmb_state_type state;
    logic           lock_err_pulse;
    rxmb_cmd_type   cmd;
    logic           setup;
    logic           wr;
    logic           rd;
    logic [31:0]    cfg_q;
    logic [31:0]    data_q;
    logic [31:0]    status_q;
    logic           irq_en_q;
    logic           irq_flag_q;
    logic           err_q;
    logic           sw_ok;
    logic           enabled_state_bit;
    logic           locked_state_bit;
    logic           dev_write;
    logic           word_ok;
    logic           wr_ctrl;
    logic           wr_cfg;
    logic           wr_data;
    logic           wr_status;
    logic           wr_err;
    rxmb_sw_region_type  sw_region;
    rxmb_dev_region_type dev_region;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    // answer one cycle after setup: access phase with pready high
    assign setup = psel && !penable;
    assign wr    = psel && penable && pready && pwrite;
    assign rd    = setup && !pwrite;

    // host write strobes, one per word; region limits folded in
    assign wr_ctrl   = wr && hit(paddr, RXMB_CTRL_OFS);
    assign wr_cfg    = wr && sw_ok && hit(paddr, RXMB_CFG_OFS);
    assign wr_data   = wr && sw_ok && hit(paddr, RXMB_DATA_OFS);
    assign wr_status = wr && sw_ok && hit(paddr, RXMB_STATUS_OFS);
    assign wr_err    = wr && hit(paddr, RXMB_ERR_OFS);

    assign cmd.enable_toggle_trigger = wr_ctrl && pwdata[RXMB_ENABLE_TOGGLE_BIT];
    assign cmd.lock_toggle_trigger   = wr_ctrl && pwdata[RXMB_LOCK_TOGGLE_BIT]
                                       && !pwdata[RXMB_ENABLE_TOGGLE_BIT];

    rxmb_fsm rxmb_fsm_inst (
        .clk        (clk),
        .srst       (srst),
        .cmd        (cmd),
        .ev         (ev),
        .state_q    (state),
        .lock_error (lock_err_pulse)
    );

    // access regions per state
    always_comb begin
        sw_region  = REG_NONE;
        dev_region = DEV_NONE;
        case (state)
            ST_IDLE:                 dev_region = DEV_SEARCH;
            ST_HOST_DISABLED:        sw_region  = REG_CONFIG;
            ST_HOST_DISABLED_LOCKED: sw_region  = REG_CONFIG;
            ST_HOST_LOCKED: begin
                sw_region  = REG_MESSAGE;
                dev_region = DEV_SEARCH;
            end
            ST_LOCKED_SUBSCRIBED:    sw_region  = REG_MESSAGE;
            ST_LOCKED_RECEIVING:     sw_region  = REG_MESSAGE;
            ST_SUBSCRIBED:           sw_region  = REG_NONE;
            ST_RECEIVING:            sw_region  = REG_NONE;
            ST_STATUS_UPDATING:      dev_region = DEV_RECEIVE;
            default:                 sw_region  = REG_NONE;
        endcase
    end

    always_comb begin
        enabled_state_bit = 1'b1;
        locked_state_bit  = 1'b0;
        case (state)
            ST_HOST_DISABLED:        enabled_state_bit = 1'b0;
            ST_HOST_DISABLED_LOCKED: begin
                enabled_state_bit = 1'b0;
                locked_state_bit  = 1'b1;
            end
            ST_HOST_LOCKED, ST_LOCKED_SUBSCRIBED, ST_LOCKED_RECEIVING:
                locked_state_bit  = 1'b1;
            default:                 locked_state_bit  = 1'b0;
        endcase
    end

    // status update is the only path by which the device writes
    assign dev_write = upd.valid && dev_region == DEV_RECEIVE;
    // config only in config region; data/status in either host region
    assign sw_ok = (sw_region != REG_NONE) &&
                   !(hit(paddr, RXMB_CFG_OFS) && sw_region != REG_CONFIG);

    // word decode for the setup cycle; unmapped words fail
    always_comb begin
        word_ok = 1'b0;
        case (paddr)
            RXMB_CTRL_OFS, RXMB_ERR_OFS:                  word_ok = 1'b1;
            RXMB_CFG_OFS, RXMB_DATA_OFS, RXMB_STATUS_OFS: word_ok = sw_ok;
            default:                                      word_ok = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            pready <= 1'b0;
        end else begin
            pready <= setup;
        end
    end

    // blocked or unmapped accesses answer with an error
    always_ff @(posedge clk) begin
        if (srst) begin
            pslverr <= 1'b0;
        end else if (setup) begin
            pslverr <= !word_ok;
        end else begin
            pslverr <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            prdata <= RXMB_ZERO_WORD;
        end else if (rd) begin
            prdata <= RXMB_ZERO_WORD;
            if (hit(paddr, RXMB_CTRL_OFS)) begin
                // internal state hidden, only the two state bits
                prdata[RXMB_IE_BIT]            <= irq_en_q;
                prdata[RXMB_IF_BIT]            <= irq_flag_q;
                prdata[RXMB_ENABLED_STATE_BIT] <= enabled_state_bit;
                prdata[RXMB_LOCKED_STATE_BIT]  <= locked_state_bit;
                prdata[RXMB_BUFFER_TYPE_BIT]   <= cfg_q[RXMB_BUFFER_TYPE_BIT];
                prdata[RXMB_DIRECTION_BIT]     <= cfg_q[RXMB_DIRECTION_BIT];
            end else if (hit(paddr, RXMB_ERR_OFS)) begin
                prdata[RXMB_LOCK_ERROR_BIT] <= err_q;
            end else if (sw_ok && hit(paddr, RXMB_CFG_OFS)) begin
                prdata <= cfg_q;
            end else if (sw_ok && hit(paddr, RXMB_DATA_OFS)) begin
                prdata <= data_q;
            end else if (sw_ok && hit(paddr, RXMB_STATUS_OFS)) begin
                prdata <= status_q;
            end
        end else if (pready) begin
            prdata <= RXMB_ZERO_WORD;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            cfg_q <= RXMB_RESET_WORD;
        end else if (wr_cfg) begin
            cfg_q <= pwdata;
        end
    end

    // device only writes in status update, host only in its regions
    always_ff @(posedge clk) begin
        if (srst) begin
            data_q <= RXMB_RESET_WORD;
        end else if (dev_write) begin
            data_q <= upd.data;
        end else if (wr_data) begin
            data_q <= pwdata;
        end
    end

    // the two writers own disjoint states, so they never collide
    always_ff @(posedge clk) begin
        if (srst) begin
            status_q <= RXMB_RESET_WORD;
        end else if (dev_write) begin
            status_q <= upd.status;
        end else if (wr_status) begin
            status_q <= pwdata;
        end
    end

    // irq enable follows every control write, whatever the state
    always_ff @(posedge clk) begin
        if (srst) begin
            irq_en_q <= 1'b0;
        end else if (wr_ctrl) begin
            irq_en_q <= pwdata[RXMB_IE_BIT];
        end
    end

    // flag cleared by writing one; device set wins
    always_ff @(posedge clk) begin
        if (srst) begin
            irq_flag_q <= 1'b0;
        end else if (dev_write) begin
            irq_flag_q <= 1'b1;
        end else if (wr_ctrl && pwdata[RXMB_IF_BIT]) begin
            irq_flag_q <= 1'b0;
        end
    end

    // lock error sticky, write one to clear, set wins
    always_ff @(posedge clk) begin
        if (srst) begin
            err_q <= 1'b0;
        end else if (lock_err_pulse) begin
            err_q <= 1'b1;
        end else if (wr_err && pwdata[RXMB_LOCK_ERROR_BIT]) begin
            err_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            search_included <= 1'b0;
        end else begin
            search_included <= dev_region == DEV_SEARCH;
        end
    end

    // configuration shown to the search only while it may read it
    always_ff @(posedge clk) begin
        if (srst) begin
            search_cfg <= RXMB_ZERO_WORD;
        end else begin
            search_cfg <= (dev_region == DEV_SEARCH) ? cfg_q : RXMB_ZERO_WORD;
        end
    end

    // shadow data never reaches the buffer words
    always_ff @(posedge clk) begin
        if (srst) begin
            shadow_select <= 1'b0;
        end else begin
            shadow_select <= shadow_valid && (state == ST_RECEIVING ||
                                              state == ST_LOCKED_RECEIVING);
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            lock_error_flag <= 1'b0;
        end else begin
            lock_error_flag <= err_q;
        end
    end

    // shadow data is consumed outside; kept as an input for the shadow path
    logic shadow_unused;
    assign shadow_unused = ^shadow_data;
endmodule
`default_nettype wire

// file: core/rxmb_pkg.sv
package rxmb_pkg;
    // register map (byte addresses, one word each)
    localparam logic [7:0] RXMB_CTRL_OFS   = 8'h00;
    localparam logic [7:0] RXMB_CFG_OFS    = 8'h04;
    localparam logic [7:0] RXMB_DATA_OFS   = 8'h08;
    localparam logic [7:0] RXMB_STATUS_OFS = 8'h0C;
    localparam logic [7:0] RXMB_ERR_OFS    = 8'h10;

    // control/status word field positions
    localparam int RXMB_ENABLE_TOGGLE_BIT = 0;
    localparam int RXMB_LOCK_TOGGLE_BIT   = 1;
    localparam int RXMB_IE_BIT            = 2;
    localparam int RXMB_IF_BIT            = 3;
    localparam int RXMB_ENABLED_STATE_BIT = 4;
    localparam int RXMB_LOCKED_STATE_BIT  = 5;
    localparam int RXMB_BUFFER_TYPE_BIT   = 6;
    localparam int RXMB_DIRECTION_BIT     = 7;

    // error word field position
    localparam int RXMB_LOCK_ERROR_BIT    = 0;

    localparam logic [31:0] RXMB_RESET_WORD = 32'h0000_0000;
    localparam logic [31:0] RXMB_ZERO_WORD  = 32'h0000_0000;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_HOST_DISABLED,
        ST_HOST_DISABLED_LOCKED,
        ST_HOST_LOCKED,
        ST_SUBSCRIBED,
        ST_LOCKED_SUBSCRIBED,
        ST_RECEIVING,
        ST_LOCKED_RECEIVING,
        ST_STATUS_UPDATING
    } rxmb_state_type;

    typedef enum logic [1:0] {
        REG_NONE,
        REG_CONFIG,
        REG_MESSAGE
    } rxmb_sw_region_type;

    typedef enum logic [1:0] {
        DEV_NONE,
        DEV_SEARCH,
        DEV_RECEIVE
    } rxmb_dev_region_type;

    // protocol engine events, one-cycle pulses
    typedef struct packed {
        logic filter_match;
        logic slot_begin_transition;
        logic slot_or_segment_begin;
    } rxmb_events_type;

    // device-side status write during status update
    typedef struct packed {
        logic        valid;
        logic [31:0] status;
        logic [31:0] data;
    } rxmb_update_type;

    typedef struct packed {
        logic enable_toggle_trigger;
        logic lock_toggle_trigger;
    } rxmb_cmd_type;
endpackage

// file: core/rxmb_fsm.sv
`timescale 1ns/100ps
`default_nettype none
module rxmb_fsm
    import rxmb_pkg::*;
(
    // clock and reset
    input  wire logic            clk,
    input  wire logic            srst,
    // commands and events
    input  wire rxmb_cmd_type    cmd,
    input  wire rxmb_events_type ev,
    // state
    output var  rxmb_state_type  state_q,
    output logic                 lock_error
);
    rxmb_state_type mid;
    rxmb_state_type state_d;

    // device transition first, then host transition on the result
    always_comb begin
        mid = state_q;
        case (state_q)
            ST_IDLE:              if (ev.filter_match) mid = ST_SUBSCRIBED;
            ST_HOST_LOCKED:       if (ev.filter_match) mid = ST_LOCKED_SUBSCRIBED;
            ST_SUBSCRIBED:        if (ev.slot_begin_transition) mid = ST_RECEIVING;
            ST_LOCKED_SUBSCRIBED: if (ev.slot_begin_transition) mid = ST_LOCKED_RECEIVING;
            ST_RECEIVING:         if (ev.slot_or_segment_begin) mid = ST_STATUS_UPDATING;
            ST_LOCKED_RECEIVING:  if (ev.slot_or_segment_begin) mid = ST_HOST_LOCKED;
            ST_STATUS_UPDATING:   mid = ST_IDLE;
            default:              mid = state_q;
        endcase
    end

    always_comb begin
        state_d    = mid;
        lock_error = 1'b0;
        // in receiving the host lock is judged on the original state
        if (cmd.lock_toggle_trigger && state_q == ST_RECEIVING) begin
            lock_error = 1'b1;
        end else if (cmd.lock_toggle_trigger) begin
            case (mid)
                ST_IDLE:                 state_d = ST_HOST_LOCKED;
                ST_SUBSCRIBED:           state_d = ST_LOCKED_SUBSCRIBED;
                ST_RECEIVING:            state_d = ST_LOCKED_RECEIVING;
                ST_STATUS_UPDATING:      state_d = ST_STATUS_UPDATING;
                ST_HOST_DISABLED:        state_d = ST_HOST_DISABLED_LOCKED;
                ST_HOST_DISABLED_LOCKED: state_d = ST_HOST_DISABLED;
                ST_HOST_LOCKED:          state_d = ST_IDLE;
                ST_LOCKED_SUBSCRIBED:    state_d = ST_SUBSCRIBED;
                ST_LOCKED_RECEIVING:     state_d = ST_RECEIVING;
                default:                 state_d = mid;
            endcase
        end else if (cmd.enable_toggle_trigger) begin
            // enable/disable has lower priority than subscribe
            case (mid)
                ST_HOST_DISABLED:        state_d = ST_IDLE;
                ST_HOST_DISABLED_LOCKED: state_d = ST_HOST_LOCKED;
                ST_IDLE:                 state_d = ST_HOST_DISABLED;
                ST_HOST_LOCKED:          state_d = ST_HOST_DISABLED_LOCKED;
                default:                 state_d = mid;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_q <= ST_HOST_DISABLED;
        end else begin
            state_q <= state_d;
        end
    end
endmodule
`default_nettype wire

// file: dv/rxmb_checker.sv
`timescale 1ns/100ps
`default_nettype none
module rxmb_checker
    import rxmb_pkg::*;
(
    // clock and reset
    input wire logic            clk,
    input wire logic            srst,
    // apb
    input wire logic            psel,
    input wire logic            penable,
    input wire logic            pwrite,
    input wire logic [7:0]      paddr,
    input wire logic [31:0]     pwdata,
    input wire logic [31:0]     prdata,
    input wire logic            pready,
    input wire logic            pslverr,
    // engine
    input wire rxmb_events_type ev,
    input wire rxmb_update_type upd,
    input wire logic            shadow_valid,
    input wire logic [31:0]     shadow_data,
    // search view
    input wire logic            search_included,
    input wire logic [31:0]     search_cfg,
    input wire logic            shadow_select,
    input wire logic            lock_error_flag
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    wire logic lck_wr = psel && penable && pready && pwrite && pwdata[RXMB_LOCK_TOGGLE_BIT];
    ctrl_always_open_a: assert property (psel && !penable && paddr == RXMB_CTRL_OFS
        |=> pready && !pslverr) else $error("control access not answered");
    ready_one_cycle_a: assert property (pready |=> !pready)
        else $error("ready held too long");
    quiet_read_bus_a: assert property (!pready |-> prdata == RXMB_ZERO_WORD)
        else $error("read data outside access");
    reset_outputs_a: assert property ($fell(srst)
        |-> !search_included && !shadow_select && !lock_error_flag)
        else $error("outputs not cleared by reset");
    cfg_hidden_a: assert property (!search_included |-> search_cfg == RXMB_ZERO_WORD)
        else $error("search view shown while unsearched");
    shadow_path_a: assert property (shadow_select
        |-> !search_included && $past(shadow_valid)) else $error("shadow select bad");
    subscribe_leaves_a: assert property (search_included && ev.filter_match
        |-> ##[1:2] !search_included) else $error("match did not subscribe");
    lock_error_cause_a: assert property ($rose(lock_error_flag)
        |-> $past(lck_wr) || $past(lck_wr, 2)) else $error("lock error without lock");
    error_with_ready_a: assert property (pslverr |-> pready)
        else $error("slave error outside access");
endmodule
bind rxmb_top rxmb_checker rxmb_checker_inst (
    .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ev(ev), .upd(upd), .shadow_valid(shadow_valid),
    .shadow_data(shadow_data), .search_included(search_included),
    .search_cfg(search_cfg), .shadow_select(shadow_select),
    .lock_error_flag(lock_error_flag)
);
`default_nettype wire

// file: dv/rxmb_engine_model.sv
`timescale 1ns/100ps
`default_nettype none
module rxmb_engine_model
    import rxmb_pkg::*;
#(
    parameter logic [31:0] UPD_STATUS = 32'h0000_5A01,
    parameter logic [31:0] UPD_DATA   = 32'hC0DE_0042
)
(
    // clock and reset
    input wire logic            clk,
    input wire logic            srst,
    // bench requests
    input wire rxmb_events_type ev_req,
    input wire logic            upd_en,
    // engine side
    output var rxmb_events_type ev,
    output var rxmb_update_type upd,
    output var logic            shadow_valid,
    output var logic [31:0]     shadow_data
);
    logic [1:0]  upd_cnt_q;
    logic [31:0] noise_q;
    assign ev = ev_req;
    // update held two cycles so it spans the one status-update cycle
    assign upd.valid = upd_cnt_q != 2'h0;
    assign upd.status = upd.valid ? UPD_STATUS : noise_q;
    assign upd.data = upd.valid ? UPD_DATA : ~noise_q;
    // shadow words never repeat, so a stored copy would show
    assign shadow_data = noise_q;
    always_ff @(posedge clk) begin
        noise_q <= srst ? 32'h1357_9BDF : {noise_q[30:0], noise_q[31] ^ noise_q[21]};
    end
    always_ff @(posedge clk) begin
        if (srst || ev.slot_or_segment_begin) begin
            shadow_valid <= 1'b0;
        end else if (ev.slot_begin_transition) begin
            shadow_valid <= 1'b1;
        end
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            upd_cnt_q <= 2'h0;
        end else if (ev.slot_or_segment_begin && upd_en) begin
            upd_cnt_q <= 2'h2;
        end else if (upd_cnt_q != 2'h0) begin
            upd_cnt_q <= upd_cnt_q - 2'h1;
        end
    end
endmodule
`default_nettype wire

// file: dv/test_rxmb_top.sv
`timescale 1ns/100ps
`default_nettype none
module test_rxmb_top;
    import rxmb_pkg::*;
    localparam logic [31:0] ENT = 32'h1 << RXMB_ENABLE_TOGGLE_BIT;
    localparam logic [31:0] LKT = 32'h1 << RXMB_LOCK_TOGGLE_BIT;
    localparam logic [31:0] IE  = 32'h1 << RXMB_IE_BIT;
    localparam logic [31:0] IFL = 32'h1 << RXMB_IF_BIT;
    localparam logic [31:0] ENS = 32'h1 << RXMB_ENABLED_STATE_BIT;
    localparam logic [31:0] LKS = 32'h1 << RXMB_LOCKED_STATE_BIT;
    localparam logic [31:0] CFG_W = 32'h0000_0025;
    localparam logic [31:0] U_ST  = 32'h0000_5A01;
    localparam logic [31:0] U_DT  = 32'hC0DE_0042;
    localparam rxmb_events_type NO = 3'b000;
    localparam rxmb_events_type FM = 3'b100;
    localparam rxmb_events_type SB = 3'b010;
    localparam rxmb_events_type SS = 3'b001;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, shadow_valid, search_included, shadow_select, lock_error_flag;
    logic [31:0] shadow_data, search_cfg;
    rxmb_events_type ev_req = NO;
    rxmb_events_type ev;
    rxmb_update_type upd;
    logic upd_en = 1'b0;
    int num_errors = 0;
    int checked = 0;
    always #2.5 clk = ~clk;
    rxmb_engine_model #(.UPD_STATUS(U_ST), .UPD_DATA(U_DT)) rxmb_engine_model_inst (
        .clk(clk), .srst(srst), .ev_req(ev_req), .upd_en(upd_en), .ev(ev), .upd(upd),
        .shadow_valid(shadow_valid), .shadow_data(shadow_data));
    rxmb_top rxmb_top_inst (
        .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ev(ev), .upd(upd), .shadow_valid(shadow_valid),
        .shadow_data(shadow_data), .search_included(search_included),
        .search_cfg(search_cfg), .shadow_select(shadow_select),
        .lock_error_flag(lock_error_flag));
    task automatic give_verdict();
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // events ride in the access cycle so they meet the write at one edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input rxmb_events_type e, output logic [31:0] rd, output logic er);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        ev_req <= e;
        @(posedge clk);
        ev_req <= NO;
        while (pready !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        if (n >= 20) begin
            num_errors++;
            give_verdict();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input rxmb_events_type e = NO);
        logic [31:0] rd;
        logic er;
        apb(1'b1, a, d, e, rd, er);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic exp_er);
        logic [31:0] rd;
        logic er;
        apb(1'b0, a, 32'h0, NO, rd, er);
        chk(rd, exp);
        chk({31'h0, er}, {31'h0, exp_er});
    endtask
    task automatic pulse(input rxmb_events_type e);
        @(posedge clk);
        ev_req <= e;
        @(posedge clk);
        ev_req <= NO;
    endtask
    initial begin
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        rdc(RXMB_CTRL_OFS, 32'h0, 1'b0);
        wr(RXMB_CFG_OFS, CFG_W);
        rdc(RXMB_CFG_OFS, CFG_W, 1'b0);
        chk({31'h0, search_included}, 32'h0);
        wr(RXMB_CTRL_OFS, ENT);
        rdc(RXMB_CTRL_OFS, ENS, 1'b0);
        rdc(RXMB_CFG_OFS, 32'h0, 1'b1);
        rdc(RXMB_DATA_OFS, 32'h0, 1'b1);
        chk({31'h0, search_included}, 32'h1);
        chk(search_cfg, CFG_W);
        pulse(FM);
        wr(RXMB_CTRL_OFS, ENT);
        rdc(RXMB_CTRL_OFS, ENS, 1'b0);
        chk({31'h0, search_included}, 32'h0);
        rdc(RXMB_STATUS_OFS, 32'h0, 1'b1);
        pulse(SB);
        upd_en <= 1'b1;
        repeat (2) @(negedge clk);
        chk({31'h0, shadow_select}, 32'h1);
        wr(RXMB_CTRL_OFS, LKT);
        rdc(RXMB_CTRL_OFS, ENS, 1'b0);
        rdc(RXMB_ERR_OFS, 32'h1, 1'b0);
        chk({31'h0, lock_error_flag}, 32'h1);
        wr(RXMB_ERR_OFS, 32'h1);
        rdc(RXMB_ERR_OFS, 32'h0, 1'b0);
        chk({31'h0, lock_error_flag}, 32'h0);
        pulse(SS);
        rdc(RXMB_CTRL_OFS, ENS | IFL, 1'b0);
        wr(RXMB_CTRL_OFS, LKT);
        rdc(RXMB_CTRL_OFS, ENS | LKS | IFL, 1'b0);
        rdc(RXMB_DATA_OFS, U_DT, 1'b0);
        rdc(RXMB_STATUS_OFS, U_ST, 1'b0);
        wr(RXMB_CTRL_OFS, IE);
        rdc(RXMB_CTRL_OFS, ENS | LKS | IFL | IE, 1'b0);
        wr(RXMB_CTRL_OFS, IE | IFL);
        rdc(RXMB_CTRL_OFS, ENS | LKS | IE, 1'b0);
        wr(RXMB_CTRL_OFS, LKT | IE, FM);
        rdc(RXMB_CTRL_OFS, ENS | IE, 1'b0);
        chk({31'h0, search_included}, 32'h0);
        upd_en <= 1'b0;
        pulse(SB);
        pulse(SS);
        rdc(RXMB_CTRL_OFS, ENS | IE, 1'b0);
        rdc(8'h14, 32'h0, 1'b1);
        wr(RXMB_CTRL_OFS, ENT | IE);
        rdc(RXMB_CTRL_OFS, IE, 1'b0);
        give_verdict();
    end
endmodule
`default_nettype wire
